// ---- iopm_board.sv ----
`timescale 1ns/10ps

// Board circuitry behind the port pins
module iopm_board (
  // Device pin drivers
  input wire logic [2:0][7:0] pin_out,
  input wire logic [2:0][7:0] pin_oe_n,
  // Board side drivers
  input wire logic [2:0][7:0] board_val,
  input wire logic [2:0][7:0] board_en,
  // Resolved pin level
  output logic [2:0][7:0] pin_lvl
);
  // Resolve each wire; a pull-up holds a pin that nobody drives
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!pin_oe_n[p][b]) begin
          pin_lvl[p][b] = pin_out[p][b];
        end else if (board_en[p][b]) begin
          pin_lvl[p][b] = board_val[p][b];
        end else begin
          pin_lvl[p][b] = 1'b1;
        end
      end
    end
  end
endmodule : iopm_board

// ---- iopm_params.svh ----
`ifndef IOPM_PARAMS_SVH
`define IOPM_PARAMS_SVH

// Register byte addresses in the processor register space
`define IOPM_OFS_A_FUNC 16'h7f93
`define IOPM_OFS_B_FUNC 16'h7f94
`define IOPM_OFS_C_FUNC 16'h7f95
`define IOPM_OFS_A_LATCH 16'h7f96
`define IOPM_OFS_B_LATCH 16'h7f97
`define IOPM_OFS_C_LATCH 16'h7f98
`define IOPM_OFS_A_LEVEL 16'h7f99
`define IOPM_OFS_B_LEVEL 16'h7f9a
// Port C level shares its address with the port C latch: reads see the pins
`define IOPM_OFS_C_LEVEL 16'h7f98
`define IOPM_OFS_A_DRIVE 16'h7f9c
`define IOPM_OFS_B_DRIVE 16'h7f9d
`define IOPM_OFS_C_DRIVE 16'h7f9e

// Reset values
`define IOPM_RST_FUNC 8'h00
`define IOPM_RST_LATCH 8'h00
`define IOPM_RST_DRIVE 8'h00
`define IOPM_RST_RDATA 8'h00

// Pins whose alternate function can drive, ports C,B,A from high to low
`define IOPM_ALT_OUT_MASK_A 8'hff
`define IOPM_ALT_OUT_MASK_B 8'h88
`define IOPM_ALT_OUT_MASK_C 8'hc2

// Level handed to an input function while its pin is plain IO
`define IOPM_ALT_IN_IDLE_B 8'h20
`define IOPM_ALT_IN_IDLE_C 8'h0c

// Serial port mode that puts the shift clock on the transmit pin
`define IOPM_SERIAL_MODE_SYNC 2'h0

`endif

// ---- iopm_pkg.sv ----
package iopm_pkg;

  // Values and enables driven by the on-chip peripherals toward the pins
  typedef struct packed {
    logic timer0_output;
    logic timer1_output;
    logic mem_output_enable_n;
    logic mem_chip_select_n;
    logic fast_store_strobe_n;
    logic fast_fetch_strobe_n;
    logic serial0_sync_data_out;
    logic serial1_sync_data_out;
    logic timer2_overflow_out;
    logic mem_write_strobe_n;
    logic mem_read_strobe_n;
    logic [1:0] serial0_mode;
    logic serial0_shift_clk;
    logic serial0_tx_data;
    logic [1:0] serial1_mode;
    logic serial1_shift_clk;
    logic serial1_tx_data;
  } iopm_periph_out_t;

  // Pin levels handed back to the peripherals
  typedef struct packed {
    logic timer2_clock_in;
    logic timer2_capture_reload_in;
    logic serial1_receive_in;
    logic ext_irq_line_four;
    logic ext_irq_line_five;
    logic ext_irq_line_six;
    logic serial0_receive_in;
    logic ext_irq_line_zero;
    logic ext_irq_line_one;
    logic timer0_count_in;
    logic timer1_count_in;
  } iopm_periph_in_t;

  // Two-signal view of a group of pins
  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
  } iopm_pin_drive_t;

endpackage : iopm_pkg

// ---- iopm_port.sv ----
`timescale 1ns/10ps
`include "iopm_params.svh"

// One eight-pin port: driver selection and pin level sampling
module iopm_port
  import iopm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Register state
  input wire logic [WIDTH-1:0] func_sel,
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] drive,
  // Alternate function side
  input wire logic [WIDTH-1:0] alt_val,
  input wire logic [WIDTH-1:0] alt_en,
  // Pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n,
  // Synchronised pin level
  output logic [WIDTH-1:0] level
);

  // Refused at elaboration: register bytes hold at most eight pins
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("iopm_port: WIDTH must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver selection

  logic [WIDTH-1:0] out_nxt; // Value to put on each pin
  logic [WIDTH-1:0] en_nxt; // High where the pin is driven
  logic [WIDTH-1:0] sync1_r; // First sampling stage, read only by sync2_r
  logic [WIDTH-1:0] sync2_r; // Settled pin level

  // Plain IO takes latch and enable, alternate takes the peripheral's pair
  assign out_nxt = (func_sel & alt_val) | (~func_sel & latch);
  assign en_nxt = (func_sel & alt_en) | (~func_sel & drive);

  // Pin outputs are registered so strobes leave glitch free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= out_nxt;
      pin_oe_n <= ~en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin level sampling

  // Two stages: pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // Level is read regardless of function select
  assign level = sync2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  io_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (~$past(func_sel) & $past(drive) & ~pin_oe_n) == (~$past(func_sel) & $past(drive)))
    else $error("enabled plain IO pin not driven");
  latch_hidden_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((~$past(func_sel) & ~$past(drive)) & ~pin_oe_n) == '0)
    else $error("disabled plain IO pin is driven");
  io_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((pin_out ^ $past(latch)) & ~$past(func_sel)) == '0)
    else $error("plain IO pin value differs from latch");
  alt_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((~pin_oe_n ^ $past(alt_en)) & $past(func_sel)) == '0)
    else $error("alternate pin drive differs from peripheral enable");
  // Wait two cycles out of reset so the cleared stages have refilled
  level_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && $past(rst_n, 2) |-> level == $past(pin_in, 2))
    else $error("pin level does not follow pin after two cycles");

endmodule : iopm_port

// ---- iopm_top.sv ----
`timescale 1ns/10ps
`include "iopm_params.svh"

// What this block does
// - select 0 makes the pin plain IO
// - drive latch only when enabled and select 0
// - select 1 hands pin to alternate function
// - port A fixed alternate function order
// - port B fixed alternate function order
// - port C fixed alternate function order
// - transmit pin: shift clock mode 0, else data
// - disabled pin still stores latch writes
// - level read shows pin in any mode
// - drive enable bits steer the tri-state driver
// - three select registers read and write
module iopm_top
  import iopm_pkg::*;
#(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pins, index 0 port A, 1 port B, 2 port C
  input wire logic [2:0][7:0] pin_in,
  output logic [2:0][7:0] pin_out,
  output logic [2:0][7:0] pin_oe_n,
  // Peripheral side
  input wire iopm_periph_out_t periph_out,
  input wire logic [2:0][7:0] periph_drive_en,
  output iopm_periph_in_t periph_in
);

  // Refused at elaboration: pin map and register bytes are eight pins a port
  if (PORT_W != 8) begin : g_bad_width
    $error("iopm_top: ports are eight pins wide");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_r; // First reset stage
  logic rst_n_i; // Synchronised reset for the whole block

  // Assert at once, release two edges later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_i <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_i <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  localparam logic [2:0][15:0] FUNC_OFS = {`IOPM_OFS_C_FUNC, `IOPM_OFS_B_FUNC, `IOPM_OFS_A_FUNC};
  localparam logic [2:0][15:0] LATCH_OFS = {`IOPM_OFS_C_LATCH, `IOPM_OFS_B_LATCH, `IOPM_OFS_A_LATCH};
  localparam logic [2:0][15:0] LEVEL_OFS = {`IOPM_OFS_C_LEVEL, `IOPM_OFS_B_LEVEL, `IOPM_OFS_A_LEVEL};
  localparam logic [2:0][15:0] DRIVE_OFS = {`IOPM_OFS_C_DRIVE, `IOPM_OFS_B_DRIVE, `IOPM_OFS_A_DRIVE};
  localparam logic [2:0][7:0] OUT_MASK = {`IOPM_ALT_OUT_MASK_C, `IOPM_ALT_OUT_MASK_B, `IOPM_ALT_OUT_MASK_A};

  logic [2:0][7:0] func_sel_r; // Alternate function select per pin
  logic [2:0][7:0] latch_r; // Output latches
  logic [2:0][7:0] drive_r; // Drive enables
  logic [2:0][7:0] level; // Synchronised pin levels
  logic [2:0] func_hit; // Address matches a select register
  logic [2:0] latch_hit; // Address matches a latch
  logic [2:0] level_hit; // Address matches a level register
  logic [2:0] drive_hit; // Address matches a drive enable
  logic [2:0][7:0] func_rd; // Per-port read terms
  logic [2:0][7:0] level_rd;
  logic [2:0][7:0] drive_rd;
  logic [2:0][7:0] latch_rd;
  logic [7:0] rd_mux; // Selected read value
  logic [7:0] rdata_nxt;

  // Per-port decode, write and read terms
  for (genvar p = 0; p < 3; p++) begin : g_reg
    assign func_hit[p] = reg_addr == FUNC_OFS[p];
    assign latch_hit[p] = reg_addr == LATCH_OFS[p];
    assign level_hit[p] = reg_addr == LEVEL_OFS[p];
    assign drive_hit[p] = reg_addr == DRIVE_OFS[p];
    assign func_rd[p] = func_hit[p] ? func_sel_r[p] : 8'h00;
    assign level_rd[p] = level_hit[p] ? level[p] : 8'h00;
    assign drive_rd[p] = drive_hit[p] ? drive_r[p] : 8'h00;
    // A shared latch/level address reads the pins
    assign latch_rd[p] = (latch_hit[p] && !level_hit[p]) ? latch_r[p] : 8'h00;

    // Writes store whatever the drive enable says
    always_ff @(posedge clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
        func_sel_r[p] <= `IOPM_RST_FUNC;
        latch_r[p] <= `IOPM_RST_LATCH;
        drive_r[p] <= `IOPM_RST_DRIVE;
      end else if (reg_wr) begin
        if (func_hit[p]) func_sel_r[p] <= reg_wdata;
        if (latch_hit[p]) latch_r[p] <= reg_wdata;
        if (drive_hit[p]) drive_r[p] <= reg_wdata;
      end
    end
  end

  // Unmapped addresses read as zero
  assign rd_mux = func_rd[0] | func_rd[1] | func_rd[2] | level_rd[0] | level_rd[1] | level_rd[2]
    | drive_rd[0] | drive_rd[1] | drive_rd[2] | latch_rd[0] | latch_rd[1] | latch_rd[2];
  assign rdata_nxt = reg_rd ? rd_mux : reg_rdata;

  // Read data held until the next read
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata <= `IOPM_RST_RDATA;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternate function map

  logic serial0_pin; // Transmit pin value for serial port 0
  logic serial1_pin; // Transmit pin value for serial port 1
  logic [2:0][7:0] alt_val; // Peripheral value per pin
  logic [2:0][7:0] alt_en; // Peripheral enable, outputs only

  // Mode 0 shifts a clock out, other modes send data
  assign serial0_pin = (periph_out.serial0_mode == `IOPM_SERIAL_MODE_SYNC) ?
    periph_out.serial0_shift_clk : periph_out.serial0_tx_data;
  assign serial1_pin = (periph_out.serial1_mode == `IOPM_SERIAL_MODE_SYNC) ?
    periph_out.serial1_shift_clk : periph_out.serial1_tx_data;

  // Port A: timers, memory strobes, sync serial data
  assign alt_val[0] = {periph_out.serial1_sync_data_out, periph_out.serial0_sync_data_out,
    periph_out.fast_fetch_strobe_n, periph_out.fast_store_strobe_n, periph_out.mem_chip_select_n,
    periph_out.mem_output_enable_n, periph_out.timer1_output, periph_out.timer0_output};
  // Port B: only transmit and overflow drive
  assign alt_val[1] = {periph_out.timer2_overflow_out, 3'h0, serial1_pin, 3'h0};
  // Port C: transmit and memory strobes drive
  assign alt_val[2] = {periph_out.mem_read_strobe_n, periph_out.mem_write_strobe_n,
    4'h0, serial0_pin, 1'h0};

  // Input-only functions can never turn a driver on
  for (genvar p = 0; p < 3; p++) begin : g_en
    assign alt_en[p] = periph_drive_en[p] & OUT_MASK[p];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ports

  for (genvar p = 0; p < 3; p++) begin : g_port
    iopm_port #(
      .WIDTH(8)
    ) u_port (
      .clk(clk),
      .rst_n(rst_n_i),
      .func_sel(func_sel_r[p]),
      .latch(latch_r[p]),
      .drive(drive_r[p]),
      .alt_val(alt_val[p]),
      .alt_en(alt_en[p]),
      .pin_in(pin_in[p]),
      .pin_out(pin_out[p]),
      .pin_oe_n(pin_oe_n[p]),
      .level(level[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inputs to peripherals

  logic [7:0] in_b; // Port B levels, idle where not selected
  logic [7:0] in_c; // Port C levels, idle where not selected

  // Idle level keeps interrupts and counters quiet on plain IO pins
  assign in_b = (func_sel_r[1] & level[1]) | (~func_sel_r[1] & `IOPM_ALT_IN_IDLE_B);
  assign in_c = (func_sel_r[2] & level[2]) | (~func_sel_r[2] & `IOPM_ALT_IN_IDLE_C);

  // Registered so the struct changes on clock edges only
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_in <= '{default: 1'b0, ext_irq_line_five: 1'b1, ext_irq_line_zero: 1'b1,
        ext_irq_line_one: 1'b1};
    end else begin
      periph_in <= '{timer2_clock_in: in_b[0], timer2_capture_reload_in: in_b[1],
        serial1_receive_in: in_b[2], ext_irq_line_four: in_b[4], ext_irq_line_five: in_b[5],
        ext_irq_line_six: in_b[6], serial0_receive_in: in_c[0], ext_irq_line_zero: in_c[2],
        ext_irq_line_one: in_c[3], timer0_count_in: in_c[4], timer1_count_in: in_c[5]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sel_readback_a: assert property (@(posedge clk) disable iff (!rst_n_i)
    reg_wr && func_hit[0] ##1 reg_rd && reg_addr == `IOPM_OFS_A_FUNC |=> reg_rdata == $past(reg_wdata, 2))
    else $error("port A select does not read back");
  latch_store_a: assert property (@(posedge clk) disable iff (!rst_n_i)
    reg_wr && latch_hit[1] |=> latch_r[1] == $past(reg_wdata))
    else $error("port B latch write lost");
  input_nodrive_a: assert property (@(posedge clk) disable iff (!rst_n_i)
    ##1 (pin_oe_n[1] | ~($past(func_sel_r[1]) & ~OUT_MASK[1])) == 8'hff)
    else $error("input-only alternate pin is driven");
  tx_sync_clk_a: assert property (@(posedge clk) disable iff (!rst_n_i)
    func_sel_r[2][1] && periph_out.serial0_mode == 2'h0 |=> pin_out[2][1] == $past(periph_out.serial0_shift_clk))
    else $error("serial 0 transmit pin lacks shift clock in mode 0");
  timer0_map_a: assert property (@(posedge clk) disable iff (!rst_n_i)
    func_sel_r[0][0] |=> pin_out[0][0] == $past(periph_out.timer0_output))
    else $error("timer 0 output not on port A bit 0");

endmodule : iopm_top

// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "iopm_params.svh"

module tb_top
  import iopm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [2:0][7:0] pin_in, pin_out, pin_oe_n, board_val, board_en, drv_en;
  iopm_periph_out_t periph_out;
  iopm_periph_in_t periph_in;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  iopm_top iopm_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_out(periph_out),
    .periph_drive_en(drv_en), .periph_in(periph_in));
  iopm_board iopm_board_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_val(board_val),
    .board_en(board_en), .pin_lvl(pin_in));

  ////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 reg_addr = a; reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1 chk(reg_rdata, exp, "register read");
  endtask : rd_chk

  // Write and read of the same register in consecutive cycles
  task automatic wr_rd_chk(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(reg_rdata, d, "write then read");
  endtask : wr_rd_chk

  // Let pins and synchronisers settle
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [15:0] regs[9] = '{`IOPM_OFS_A_FUNC, `IOPM_OFS_B_FUNC, `IOPM_OFS_C_FUNC,
      `IOPM_OFS_A_LATCH, `IOPM_OFS_B_LATCH, `IOPM_OFS_A_DRIVE, `IOPM_OFS_B_DRIVE,
      `IOPM_OFS_C_DRIVE, 16'h7f9f};
    for (int i = 0; i < 3; i++) chk(pin_oe_n[i], 8'hff, "oe after reset");
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
  endtask : t_reset

  task automatic t_select_rw();
    // Distinct patterns written and read back through all three select registers
    wr(`IOPM_OFS_A_FUNC, 8'h5a);
    wr(`IOPM_OFS_B_FUNC, 8'ha5);
    wr(`IOPM_OFS_C_FUNC, 8'h3c);
    rd_chk(`IOPM_OFS_A_FUNC, 8'h5a);
    rd_chk(`IOPM_OFS_B_FUNC, 8'ha5);
    rd_chk(`IOPM_OFS_C_FUNC, 8'h3c);
    wr_rd_chk(`IOPM_OFS_A_FUNC, 8'hc3);
    for (int i = 0; i < 3; i++) wr(16'h7f93 + 16'(i), 8'h00);
  endtask : t_select_rw

  task automatic t_plain_io();
    board_val[0] = 8'ha0;
    board_en[0] = 8'hf0;
    wr(`IOPM_OFS_A_LATCH, 8'h05);
    settle();
    chk(pin_oe_n[0], 8'hff, "latch only");
    rd_chk(`IOPM_OFS_A_LATCH, 8'h05);
    wr(`IOPM_OFS_A_DRIVE, 8'h0f);
    settle();
    chk(pin_oe_n[0], 8'hf0, "plain oe");
    chk(pin_out[0] & 8'h0f, 8'h05, "plain out");
    rd_chk(`IOPM_OFS_A_LEVEL, 8'ha5);
    wr(`IOPM_OFS_A_FUNC, 8'h01);
    settle();
    chk(pin_oe_n[0], 8'hf1, "alt takes pin");
    wr(`IOPM_OFS_A_FUNC, 8'h00);
    wr(`IOPM_OFS_A_DRIVE, 8'h00);
    // Port C level shares the latch address
    board_val[2] = 8'h3c;
    board_en[2] = 8'hff;
    wr(`IOPM_OFS_C_LATCH, 8'hff);
    settle();
    rd_chk(`IOPM_OFS_C_LEVEL, 8'h3c);
  endtask : t_plain_io

  task automatic t_alt_out();
    board_en = '0;
    drv_en = '1;
    periph_out.timer0_output = 1'b1;
    periph_out.mem_chip_select_n = 1'b1;
    periph_out.serial1_sync_data_out = 1'b1;
    periph_out.serial1_mode = `IOPM_SERIAL_MODE_SYNC;
    periph_out.serial1_shift_clk = 1'b1;
    periph_out.serial0_mode = 2'h2;
    periph_out.serial0_tx_data = 1'b1;
    periph_out.mem_read_strobe_n = 1'b1;
    for (int i = 0; i < 3; i++) wr(16'h7f93 + 16'(i), 8'hff);
    settle();
    chk(pin_oe_n[0], 8'h00, "port a alt oe");
    chk(pin_out[0], 8'h89, "port a alt out");
    chk(pin_oe_n[1], 8'h77, "port b alt oe");
    chk(pin_out[1] & 8'h88, 8'h08, "port b sync clock");
    chk(pin_oe_n[2], 8'h3d, "port c alt oe");
    chk(pin_out[2] & 8'hc2, 8'h82, "port c alt out");
    periph_out.serial1_mode = 2'h1;
    periph_out.timer2_overflow_out = 1'b1;
    periph_out.serial0_mode = `IOPM_SERIAL_MODE_SYNC;
    periph_out.serial0_shift_clk = 1'b1;
    periph_out.serial0_tx_data = 1'b0;
    settle();
    chk(pin_out[1] & 8'h88, 8'h80, "port b tx data");
    chk(pin_out[2] & 8'h02, 8'h02, "port c shift clock");
    drv_en = '0;
    settle();
    chk(pin_oe_n[0], 8'hff, "alt released");
  endtask : t_alt_out

  task automatic t_alt_in();
    wr(`IOPM_OFS_C_FUNC, 8'h01);
    board_val[2] = 8'h01;
    board_en[2] = 8'hff;
    settle();
    chk({7'h00, periph_in.serial0_receive_in}, 8'h01, "receive high");
    chk({7'h00, periph_in.ext_irq_line_zero}, 8'h01, "irq idle");
    board_val[2] = 8'h00;
    settle();
    chk({7'h00, periph_in.serial0_receive_in}, 8'h00, "receive low");
    chk({7'h00, periph_in.ext_irq_line_zero}, 8'h01, "irq still idle");
  endtask : t_alt_in

  ////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    periph_out = '0;
    drv_en = '0;
    board_val = '0;
    board_en = '0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_select_rw();
    t_plain_io();
    t_alt_out();
    t_alt_in();
    complete_run();
  end
endmodule : tb_top
